// ### flash_ctl_defines.svh
// flash_ctl_defines.svh - offsets, commands, state codes and timing of the
// flash program/erase controller. Definitions only; included by bare name.
`ifndef FLASH_CTL_DEFINES_SVH
`define FLASH_CTL_DEFINES_SVH

// --------------------------------------------------------------
// register file addresses (12-bit)
// --------------------------------------------------------------
`define ADDR_CMD_STAT 12'hFF8
`define ADDR_PAGE_PROT 12'hFF9
`define ADDR_KHZ_HI 12'hFFA
`define ADDR_KHZ_LO 12'hFFB

// --------------------------------------------------------------
// command codes
// --------------------------------------------------------------
`define CMD_RESET 8'h00
`define CMD_UNLOCK1 8'h73
`define CMD_UNLOCK2 8'h8C
`define CMD_PAGE_ERASE 8'h95
`define CMD_MASS_ERASE 8'h63
`define CMD_PROT_SEL 8'h5E

// --------------------------------------------------------------
// status codes, field positions, reset values
// --------------------------------------------------------------
`define ST_LOCKED 8'h00
`define ST_UNLOCK1 8'h01
`define ST_UNLOCK2 8'h02
`define ST_UNLOCKED 8'h03
`define ST_PROT_SEL 8'h04
`define ST_PROGRAM 8'h08
`define ST_ERASE 8'h10
`define PAGE_MSB 6
`define ADDR_PAGE_LSB 9
`define SECT_MSB 4
`define SECT_LSB 2
`define PROT_RESET 8'h00
`define PAGE_RESET 8'h00
`define KHZ_RESET 16'h0000

// --------------------------------------------------------------
// timing: one microsecond tick is built by adding this step in kHz
// --------------------------------------------------------------
`define KHZ_PER_MHZ 17'h003E8
`define PROG_TIME_US 14'h0028
`define ERASE_TIME_US 14'h2710

`endif

// ### flash_ctl_pkg.sv
// flash_ctl_pkg.sv - types shared by the flash program/erase controller.
// Assumes flash_ctl_defines.svh holds the numeric constants.
package flash_ctl_pkg;

   // controller sequencing states
   typedef enum logic [2:0] {
      S_LOCKED,
      S_UNLOCK1,
      S_UNLOCK2,
      S_UNLOCKED,
      S_PROT_SEL,
      S_PROGRAM,
      S_ERASE
   } ctl_state_t;

endpackage

// ### flash_program_erase_controller.sv
// flash_program_erase_controller.sv - lock/unlock sequencer, sector protect,
// byte program and page erase timing for the on-chip flash array.
// Assumes register-file and program-memory strobes, option bits and debug
// read requests all come from logic on i_core_clk; the array obeys levels.
//
// Summary of operation
// R1: 16-bit kHz value from two byte registers sets all program/erase timing.
// R2: software keeps the clock between 32 kHz and 20 MHz for operations.
// R3: read-protect option refuses debug and bypass reads of user flash.
// R4: every reset leaves the controller locked.
// R5: out-of-order command or page-select writes relock the controller.
// R6: unlock is 00h, page, 73h, 8Ch, same page again.
// R7: command 5Eh maps the shared address onto sector protect.
// R8: sector protect bits can only be set by user writes.
// R9: reset clears sector protect to zero.
// R10: any command write deselects sector protect.
// R11: write-protect option blocks every program and erase.
// R12: program memory writes only program bytes inside the unlocked page.
// R13: programming only clears bits; erase restores FFh.
// R14: cpu held idle during program or erase; interrupts wait.
// R15: writing 00h while unlocked leaves programming mode, locked.
// R16: bytes in protected sectors are never programmed.
// R17: software programs a location at most twice between erases.
// R18: command 95h when unlocked erases the selected 512-byte page.
// R19: after page erase the controller relocks and the cpu resumes.
// R20: page erase only happens in unprotected sectors.
// R21: mass erase is never done for user code.
// R22: page field gives program memory address bits 15 down to 9.
// R23: readable status field reports the controller state.
// R24: pulses are timed by microsecond ticks scaled from the kHz value; the code ticks at most once per cycle, so pulses run long below 1000 kHz.
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"

module flash_program_erase_controller
   import flash_ctl_pkg::*;
#(
   parameter logic [13:0] ERASE_US = `ERASE_TIME_US
)
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [11:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_pm_wr,
   input wire logic [15:0] i_pm_addr,
   input wire logic [7:0] i_pm_wdata,
   input wire logic i_read_protect,
   input wire logic i_write_protect,
   input wire logic i_ext_rd_req,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   output logic o_ext_rd_grant,
   output logic o_ext_rd_refused,
   output logic o_cpu_hold,
   output logic o_fl_prog,
   output logic o_fl_erase,
   output logic [15:0] o_fl_addr,
   output logic [7:0] o_fl_wdata
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      ctl_state_t st;
      logic page_ok;
      logic [7:0] page;
      logic [7:0] prot;
      logic [15:0] khz;
      logic [16:0] acc;
      logic [13:0] us;
      logic [7:0] rdata;
      logic rvalid;
      logic grant;
      logic refused;
      logic hold;
      logic prog;
      logic erase;
      logic [15:0] faddr;
      logic [7:0] fdata;
   } ctl_regs_t;

   ctl_regs_t r_q;
   ctl_regs_t r_d;

   // sector number of a page
   function automatic logic [2:0] sector_of(input logic [7:0] pg);
      sector_of = pg[`SECT_MSB:`SECT_LSB];
   endfunction

   // true when the page may be changed by user code
   function automatic logic page_free(input logic [7:0] pg, input logic [7:0] pr,
                                      input logic wp, input logic [15:0] khz);
      page_free = !pr[sector_of(pg)] && !wp && (khz != `KHZ_RESET);
   endfunction

   // status code of a state
   function automatic logic [7:0] status_of(input ctl_state_t s);
      unique case (s)
         S_LOCKED: status_of = `ST_LOCKED;
         S_UNLOCK1: status_of = `ST_UNLOCK1;
         S_UNLOCK2: status_of = `ST_UNLOCK2;
         S_UNLOCKED: status_of = `ST_UNLOCKED;
         S_PROT_SEL: status_of = `ST_PROT_SEL;
         S_PROGRAM: status_of = `ST_PROGRAM;
         S_ERASE: status_of = `ST_ERASE;
         default: status_of = `ST_LOCKED;
      endcase
   endfunction

   logic cmd_wr;
   logic pg_wr;
   logic busy;
   logic [16:0] acc_sum;
   logic tick;
   logic in_page;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      r_d = r_q;
      cmd_wr = i_reg_wr && (i_reg_addr == `ADDR_CMD_STAT);
      pg_wr = i_reg_wr && (i_reg_addr == `ADDR_PAGE_PROT);
      busy = (r_q.st == S_PROGRAM) || (r_q.st == S_ERASE);
      in_page = (i_pm_addr[15:`ADDR_PAGE_LSB] == r_q.page[`PAGE_MSB:0]); // [R12] [R22]

      // microsecond tick: add 1000 kHz per cycle, wrap at the kHz value
      acc_sum = r_q.acc + `KHZ_PER_MHZ; // [R24]
      tick = 1'b0;
      if (busy)
      begin
         if (acc_sum >= {1'b0, r_q.khz})
         begin
            tick = 1'b1;
            r_d.acc = acc_sum - {1'b0, r_q.khz};
         end
         else
         begin
            r_d.acc = acc_sum;
         end
         if (tick)
         begin
            r_d.us = r_q.us + 14'h0001;
         end
      end

      // kHz value registers, writable only while idle
      if (i_reg_wr && !busy && i_reg_addr == `ADDR_KHZ_HI)
         r_d.khz[15:8] = i_reg_wdata; // [R1]
      if (i_reg_wr && !busy && i_reg_addr == `ADDR_KHZ_LO)
         r_d.khz[7:0] = i_reg_wdata; // [R1]

      // sequencer
      unique case (r_q.st)
         S_LOCKED:
         begin
            if (pg_wr)
            begin
               r_d.page = i_reg_wdata;
               r_d.page_ok = 1'b1;
            end
            else if (cmd_wr && i_reg_wdata == `CMD_UNLOCK1 && r_q.page_ok)
               r_d.st = S_UNLOCK1; // [R6]
            else if (cmd_wr && i_reg_wdata == `CMD_PROT_SEL)
               r_d.st = S_PROT_SEL; // [R7]
            else if (cmd_wr)
               r_d.page_ok = 1'b0; // [R5]
         end
         S_UNLOCK1:
         begin
            if (cmd_wr && i_reg_wdata == `CMD_UNLOCK2)
               r_d.st = S_UNLOCK2; // [R6]
            else if (cmd_wr || pg_wr)
               r_d.st = S_LOCKED; // [R5]
         end
         S_UNLOCK2:
         begin
            if (pg_wr && i_reg_wdata == r_q.page)
               r_d.st = S_UNLOCKED; // [R6]
            else if (cmd_wr || pg_wr)
               r_d.st = S_LOCKED; // [R5]
         end
         S_UNLOCKED:
         begin
            if (cmd_wr && i_reg_wdata == `CMD_PAGE_ERASE
                && page_free(r_q.page, r_q.prot, i_write_protect, r_q.khz))
            begin
               r_d.st = S_ERASE; // [R18] [R20] [R11]
               r_d.faddr = {r_q.page[`PAGE_MSB:0], 9'h000}; // [R22]
               r_d.erase = 1'b1;
               r_d.hold = 1'b1; // [R14]
            end
            else if (cmd_wr && i_reg_wdata == `CMD_PROT_SEL)
            begin
               r_d.st = S_PROT_SEL; // [R7]
            end
            else if (cmd_wr || pg_wr)
            begin
               r_d.st = S_LOCKED; // [R15] [R5] [R21]
            end
            else if (i_pm_wr && in_page
                     && page_free(r_q.page, r_q.prot, i_write_protect, r_q.khz))
            begin
               r_d.st = S_PROGRAM; // [R12] [R16] [R11]
               r_d.faddr = i_pm_addr;
               r_d.fdata = i_pm_wdata; // [R13]
               r_d.prog = 1'b1;
               r_d.hold = 1'b1; // [R14]
            end
         end
         S_PROT_SEL:
         begin
            if (pg_wr)
               r_d.prot = r_q.prot | i_reg_wdata; // [R8]
            if (cmd_wr)
               r_d.st = S_LOCKED; // [R10]
         end
         S_PROGRAM, S_ERASE:
         begin
            if (r_q.us == ((r_q.st == S_PROGRAM) ? `PROG_TIME_US : ERASE_US))
            begin
               r_d.st = (r_q.st == S_PROGRAM) ? S_UNLOCKED : S_LOCKED; // [R19]
               r_d.prog = 1'b0;
               r_d.erase = 1'b0;
               r_d.hold = 1'b0; // [R14]
               r_d.us = 14'h0000;
               r_d.acc = 17'h00000;
            end
         end
      endcase
      if (r_d.st == S_LOCKED && r_q.st != S_LOCKED)
      begin
         r_d.page_ok = 1'b0;
      end

      // register read data, one cycle after the read strobe
      r_d.rvalid = i_reg_rd;
      r_d.rdata = 8'h00;
      if (i_reg_rd)
      begin
         unique case (i_reg_addr)
            `ADDR_CMD_STAT: r_d.rdata = status_of(r_q.st); // [R23]
            `ADDR_PAGE_PROT: r_d.rdata = (r_q.st == S_PROT_SEL) ? r_q.prot : r_q.page; // [R7]
            `ADDR_KHZ_HI: r_d.rdata = r_q.khz[15:8];
            `ADDR_KHZ_LO: r_d.rdata = r_q.khz[7:0];
            default: r_d.rdata = 8'h00;
         endcase
      end

      // external (debug or bypass) read gating
      r_d.grant = i_ext_rd_req && !i_read_protect; // [R3]
      r_d.refused = i_ext_rd_req && i_read_protect; // [R3]
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         r_q <= '0; // [R4] [R9]
         r_q.st <= S_LOCKED;
         r_q.prot <= `PROT_RESET;
         r_q.page <= `PAGE_RESET;
         r_q.khz <= `KHZ_RESET;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // outputs straight from flip-flops
   assign o_reg_rdata = r_q.rdata;
   assign o_reg_rvalid = r_q.rvalid;
   assign o_ext_rd_grant = r_q.grant;
   assign o_ext_rd_refused = r_q.refused;
   assign o_cpu_hold = r_q.hold;
   assign o_fl_prog = r_q.prog;
   assign o_fl_erase = r_q.erase;
   assign o_fl_addr = r_q.faddr;
   assign o_fl_wdata = r_q.fdata;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   a_prot_set_only: assert property (r_q.prot == ($past(r_q.prot) | r_q.prot)) // [R8]
      else $error("sector protect bit cleared");
   a_cmd_deselects: assert property (r_q.st == S_PROT_SEL && cmd_wr // [R10]
      |=> r_q.st == S_LOCKED)
      else $error("command write did not deselect protect");
   a_bad_order_locks: assert property (r_q.st == S_UNLOCK1 && pg_wr // [R5]
      |=> r_q.st == S_LOCKED)
      else $error("out of order write did not lock");
   a_unlock_needs_page: assert property (r_q.st == S_UNLOCK2 && pg_wr // [R6]
      && i_reg_wdata != r_q.page |=> r_q.st == S_LOCKED)
      else $error("unlocked with wrong page");
   a_wp_blocks_ops: assert property (i_write_protect && r_q.st == S_UNLOCKED // [R11]
      |=> !r_q.prog && !r_q.erase)
      else $error("operation started under write protect");
   a_prog_in_page: assert property ($rose(r_q.prog) // [R12]
      |-> r_q.faddr[15:`ADDR_PAGE_LSB] == r_q.page[`PAGE_MSB:0])
      else $error("program outside unlocked page");
   a_prog_unprot: assert property ($rose(r_q.prog) |-> !r_q.prot[sector_of(r_q.page)]) // [R16]
      else $error("program in protected sector");
   a_erase_unprot: assert property ($rose(r_q.erase) |-> !r_q.prot[sector_of(r_q.page)]) // [R20]
      else $error("erase in protected sector");
   a_hold_busy: assert property (r_q.hold == (r_q.prog || r_q.erase)) // [R14]
      else $error("cpu hold not matching busy");
   a_erase_relocks: assert property ($fell(r_q.erase) |-> r_q.st == S_LOCKED) // [R19]
      else $error("erase end did not lock");
   a_no_mass_erase: assert property (cmd_wr && i_reg_wdata == `CMD_MASS_ERASE && !busy // [R21]
      |=> !r_q.erase && r_q.st != S_UNLOCKED)
      else $error("mass erase accepted");
   a_exit_locks: assert property (r_q.st == S_UNLOCKED && cmd_wr // [R15]
      && i_reg_wdata == `CMD_RESET |=> r_q.st == S_LOCKED)
      else $error("00h did not lock");
   a_read_refused: assert property (i_ext_rd_req && i_read_protect |=> !o_ext_rd_grant) // [R3]
      else $error("read granted under read protect");
   a_prog_time: assert property ($rose(r_q.prog) |-> r_q.prog [*8]) // [R24]
      else $error("program pulse too short");

   c_unlock: cover property (r_q.st == S_UNLOCK2 ##1 r_q.st == S_UNLOCKED);
   c_program: cover property ($fell(r_q.prog));
   c_erase: cover property ($fell(r_q.erase));
   c_protect: cover property (r_q.st == S_PROT_SEL && pg_wr);

endmodule

// ### flash_array_model.sv
// flash_array_model.sv - behavioural flash array at the far side of the
// controller. Assumes level program/erase pulses with steady address/data.
`timescale 1ns/1ps

module flash_array_model
(
   input wire logic i_core_clk,
   input wire logic i_fl_prog,
   input wire logic i_fl_erase,
   input wire logic [15:0] i_fl_addr,
   input wire logic [7:0] i_fl_wdata
);
   logic [7:0] mem [0:65535];
   logic prog_q;
   logic erase_q;

   // ------------------------------------------------------------
   // array content
   // ------------------------------------------------------------
   // array starts fully erased
   initial
   begin
      foreach (mem[i]) mem[i] = 8'hFF;
      prog_q = 1'b0;
      erase_q = 1'b0;
   end

   // act once at the rising edge of each pulse
   always @(posedge i_core_clk)
   begin
      if (i_fl_prog && !prog_q)
         mem[i_fl_addr] = mem[i_fl_addr] & i_fl_wdata;
      if (i_fl_erase && !erase_q)
         for (int i = 0; i < 512; i++)
            mem[{i_fl_addr[15:9], 9'h000} + i] = 8'hFF;
      prog_q = i_fl_prog;
      erase_q = i_fl_erase;
   end
endmodule

// ### flash_program_erase_controller_tb.sv
// flash_program_erase_controller_tb.sv - self-checking bench of the flash
// program/erase controller. Assumes flash_array_model stands at the far side.
`timescale 1ns/1ps
`include "flash_ctl_defines.svh"

module flash_program_erase_controller_tb;
   localparam logic [6:0] PG = 7'h05;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic pm_wr = 1'b0;
   logic [15:0] pm_addr = 16'h0000;
   logic [7:0] pm_wdata = 8'h00;
   logic rd_prot = 1'b0;
   logic wr_prot = 1'b0;
   logic ext_req = 1'b0;
   logic [7:0] rdata;
   logic rvalid;
   logic grant;
   logic refused;
   logic hold;
   logic fl_prog;
   logic fl_erase;
   logic [15:0] fl_addr;
   logic [7:0] fl_wdata;
   logic [7:0] exp_mem [0:65535];
   int fails = 0;
   int checked = 0;
   int khz = 1000;

   // ------------------------------------------------------------
   // design and far side
   // ------------------------------------------------------------
   always #5 clk = ~clk;

   flash_program_erase_controller #(.ERASE_US(14'h0014)) u_flash_program_erase_controller
   (
      .i_core_clk(clk), .i_rstn(rst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_pm_wr(pm_wr),
      .i_pm_addr(pm_addr), .i_pm_wdata(pm_wdata), .i_read_protect(rd_prot),
      .i_write_protect(wr_prot), .i_ext_rd_req(ext_req), .o_reg_rdata(rdata),
      .o_reg_rvalid(rvalid), .o_ext_rd_grant(grant), .o_ext_rd_refused(refused),
      .o_cpu_hold(hold), .o_fl_prog(fl_prog), .o_fl_erase(fl_erase),
      .o_fl_addr(fl_addr), .o_fl_wdata(fl_wdata)
   );

   flash_array_model u_flash_array_model
   (
      .i_core_clk(clk), .i_fl_prog(fl_prog), .i_fl_erase(fl_erase),
      .i_fl_addr(fl_addr), .i_fl_wdata(fl_wdata)
   );

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   // answer registered one cycle after the strobe edge
   task automatic rd(input logic [11:0] a, input logic [7:0] e, input string what);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      chk("rvalid", 16'h0001, 16'(rvalid));
      chk(what, 16'(e), 16'(rdata));
   endtask

   task automatic unlock(input logic [6:0] p);
      wr(`ADDR_CMD_STAT, `CMD_RESET);
      wr(`ADDR_PAGE_PROT, {1'b0, p});
      wr(`ADDR_CMD_STAT, `CMD_UNLOCK1);
      rd(`ADDR_CMD_STAT, `ST_UNLOCK1, "st_unl1");
      wr(`ADDR_CMD_STAT, `CMD_UNLOCK2);
      rd(`ADDR_CMD_STAT, `ST_UNLOCK2, "st_unl2");
      wr(`ADDR_PAGE_PROT, {1'b0, p});
      rd(`ADDR_CMD_STAT, `ST_UNLOCKED, "st_unl");
   endtask

   task automatic waitidle(output int n);
      n = 0;
      while (hold && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      chk("hold_end", 16'h0000, 16'(hold));
   endtask

   task automatic prog(input logic [15:0] a, input logic [7:0] d, input bit ok);
      int n;
      int lo;
      lo = `PROG_TIME_US * khz / 1000;
      @(negedge clk);
      pm_wr = 1'b1;
      pm_addr = a;
      pm_wdata = d;
      @(negedge clk);
      pm_wr = 1'b0;
      chk("prog", 16'(ok), 16'(fl_prog));
      chk("hold", 16'(ok), 16'(hold));
      if (ok)
      begin
         chk("prog_addr", a, fl_addr);
         chk("prog_data", 16'(d), 16'(fl_wdata));
         exp_mem[a] = exp_mem[a] & d;
         rd(`ADDR_CMD_STAT, `ST_PROGRAM, "st_prog");
      end
      waitidle(n);
      // the status read above used two cycles of the pulse
      if (ok)
      begin
         chk("prog_len", 16'h0001, 16'(n + 2 >= lo && n + 2 <= lo + 2));
         rd(`ADDR_CMD_STAT, `ST_UNLOCKED, "st_after_prog");
      end
      chk("cell", 16'(exp_mem[a]), 16'(u_flash_array_model.mem[a]));
   endtask

   task automatic erase(input logic [6:0] p, input bit ok);
      int n;
      int bad;
      bad = 0;
      wr(`ADDR_CMD_STAT, `CMD_PAGE_ERASE);
      chk("erase", 16'(ok), 16'(fl_erase));
      if (ok)
      begin
         chk("erase_addr", {p, 9'h000}, fl_addr);
         for (int i = 0; i < 512; i++)
            exp_mem[{p, 9'h000} + i] = 8'hFF;
         rd(`ADDR_CMD_STAT, `ST_ERASE, "st_erase");
      end
      waitidle(n);
      if (ok)
         rd(`ADDR_CMD_STAT, `ST_LOCKED, "st_after_erase");
      // whole page against the expected image
      for (int i = 0; i < 512; i++)
         if (u_flash_array_model.mem[{p, 9'h000} + i] !== exp_mem[{p, 9'h000} + i])
            bad++;
      chk("erased", 16'h0000, 16'(bad));
   endtask

   task automatic fin(input string name);
      $display("test %s done", name);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   // watchdog at twenty thousand cycles, over forty times the expected run of about 450 cycles
   initial
   begin
      #200000;
      fails++;
      results();
   end

   initial
   begin
      logic [7:0] d;
      logic [8:0] off;
      foreach (exp_mem[i]) exp_mem[i] = 8'hFF;
      void'($urandom(32'hC444));
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      rd(`ADDR_CMD_STAT, `ST_LOCKED, "st_reset");
      rd(`ADDR_PAGE_PROT, `PAGE_RESET, "page_reset");
      // 1000 kHz gives one microsecond tick per cycle, keeps the run short
      wr(`ADDR_KHZ_HI, 8'(khz >> 8));
      wr(`ADDR_KHZ_LO, 8'(khz));
      rd(`ADDR_KHZ_HI, 8'(khz >> 8), "khz_hi");
      fin("reset");
      d = 8'($urandom);
      off = 9'($urandom);
      unlock(PG);
      prog({PG, off}, d, 1'b1);
      // 2000 kHz halves the tick rate, so the pulse must double
      khz = 2000;
      wr(`ADDR_KHZ_HI, 8'(khz >> 8));
      wr(`ADDR_KHZ_LO, 8'(khz));
      rd(`ADDR_KHZ_LO, 8'(khz), "khz_lo");
      prog({PG, off}, 8'($urandom), 1'b1);
      prog({PG + 7'h01, off}, 8'h00, 1'b0);
      wr(`ADDR_CMD_STAT, `CMD_RESET);
      rd(`ADDR_CMD_STAT, `ST_LOCKED, "st_exit");
      prog({PG, off}, 8'h00, 1'b0);
      fin("program");
      wr(`ADDR_CMD_STAT, `CMD_UNLOCK2);
      rd(`ADDR_CMD_STAT, `ST_LOCKED, "st_order1");
      wr(`ADDR_PAGE_PROT, {1'b0, PG});
      wr(`ADDR_CMD_STAT, `CMD_UNLOCK1);
      wr(`ADDR_CMD_STAT, `CMD_UNLOCK2);
      wr(`ADDR_PAGE_PROT, {1'b0, PG + 7'h01});
      rd(`ADDR_CMD_STAT, `ST_LOCKED, "st_order2");
      wr(`ADDR_PAGE_PROT, {1'b0, PG});
      wr(`ADDR_CMD_STAT, `CMD_UNLOCK1);
      wr(`ADDR_PAGE_PROT, {1'b0, PG});
      rd(`ADDR_CMD_STAT, `ST_LOCKED, "st_order3");
      fin("order");
      unlock(PG);
      erase(PG, 1'b1);
      unlock(PG);
      wr(`ADDR_CMD_STAT, `CMD_MASS_ERASE);
      chk("mass", 16'h0000, 16'(fl_erase));
      rd(`ADDR_CMD_STAT, `ST_LOCKED, "st_mass");
      fin("erase");
      // leave a programmed byte so that a refused erase can be seen
      unlock(PG);
      prog({PG, off}, 8'h00, 1'b1);
      wr(`ADDR_CMD_STAT, `CMD_PROT_SEL);
      rd(`ADDR_CMD_STAT, `ST_PROT_SEL, "st_prot");
      wr(`ADDR_PAGE_PROT, 8'h02);
      wr(`ADDR_PAGE_PROT, 8'h01);
      wr(`ADDR_PAGE_PROT, 8'h00);
      rd(`ADDR_PAGE_PROT, 8'h03, "prot");
      wr(`ADDR_CMD_STAT, `CMD_RESET);
      rd(`ADDR_CMD_STAT, `ST_LOCKED, "st_desel");
      rd(`ADDR_PAGE_PROT, {1'b0, PG}, "page_back");
      unlock(PG);
      prog({PG, off ^ 9'h001}, 8'h00, 1'b0);
      erase(PG, 1'b0);
      fin("protect");
      wr_prot = 1'b1;
      unlock(PG + 7'h04);
      prog({PG + 7'h04, off}, 8'h00, 1'b0);
      erase(PG + 7'h04, 1'b0);
      wr_prot = 1'b0;
      fin("write_protect");
      ext_req = 1'b1;
      @(negedge clk);
      chk("grant", 16'h0001, 16'(grant));
      rd_prot = 1'b1;
      @(negedge clk);
      chk("refused", 16'h0001, 16'(refused));
      chk("no_grant", 16'h0000, 16'(grant));
      ext_req = 1'b0;
      fin("read_protect");
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      rd(`ADDR_CMD_STAT, `ST_LOCKED, "st_rst2");
      wr(`ADDR_CMD_STAT, `CMD_PROT_SEL);
      rd(`ADDR_PAGE_PROT, `PROT_RESET, "prot_rst");
      fin("second_reset");
      results();
   end
endmodule
